/* qsoc_pkg.sv */
// Purpose: Shared constants for the quad switch output control block
// Assumes: Frame of one byte, command nibble first, MSB first on the wire
// Notes:   Command codes use H = 1, L = 0
package qsoc_pkg;
  localparam int unsigned FRAME_BITS   = 8;
  localparam int unsigned CHANNELS     = 4;
  localparam int unsigned CMD_MSB      = 7;
  localparam int unsigned CMD_LSB      = 4;
  localparam logic [3:0]  CMD_DIAG     = 4'h0;
  localparam logic [3:0]  CMD_READBACK = 4'hc;
  localparam logic [3:0]  CMD_ECHO     = 4'ha;
  localparam logic [3:0]  CMD_OR       = 4'h3;
  localparam logic [3:0]  CMD_AND      = 4'hf;
  localparam logic [7:0]  SHIFT_RESET  = 8'h00;
  localparam logic [3:0]  OUT_RESET    = 4'h0;
  localparam logic        MODE_RESET   = 1'b0;
  localparam logic        MODE_OR      = 1'b0;
  localparam logic        MODE_AND     = 1'b1;
  localparam logic [1:0]  DIAG_NORMAL  = 2'h3;
  localparam int unsigned SYNC_STAGES  = 2;
  // Pin lanes {sclk, cs_n, si, strap, in4..in1}: select and strap idle high
  localparam logic [7:0]  SYNC_IDLE    = 8'h50;
endpackage

/* qsoc_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module qsoc_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,    // System clock
  input  wire logic             rst_n_i,  // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i,  // Pin levels
  output logic      [WIDTH-1:0] sync_o    // Synchronised levels
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Each lane resets to its pin's idle level to avoid a false edge on release
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

/* qsoc_top.sv */
// Purpose: Command decoder and output stage control of a four channel switch
// Assumes: Serial clock and chip select much slower than clk_i, sampled here
// Notes:   Serial output driven only while chip select is low
`timescale 1ns/1ps
module qsoc_top (
  input  wire logic       clk_i,                      // System clock 100 MHz
  input  wire logic       rst_n_i,                    // Reset pin, active low
  input  wire logic       spi_sclk_i,                 // Serial clock pin
  input  wire logic       spi_cs_n_i,                 // Chip select pin, active low
  input  wire logic       spi_si_i,                   // Serial data in pin
  output logic            spi_so_o,                   // Serial data out
  output logic            spi_so_oe_o,                // Serial out enable, high drives
  input  wire logic       input_polarity_strap_i,     // High: parallel inputs active high
  input  wire logic       parallel_channel_input_1_i, // Parallel input channel 1
  input  wire logic       parallel_channel_input_2_i, // Parallel input channel 2
  input  wire logic       parallel_channel_input_3_i, // Parallel input channel 3
  input  wire logic       parallel_channel_input_4_i, // Parallel input channel 4
  input  wire logic [7:0] diag_status_i,              // Full diagnosis, two bits per channel
  input  wire logic [3:0] channel_fault_flag_i,       // Per channel fault, high = fault
  output logic            power_channel_output_1_o,   // Output channel 1 on
  output logic            power_channel_output_2_o,   // Output channel 2 on
  output logic            power_channel_output_3_o,   // Output channel 3 on
  output logic            power_channel_output_4_o,   // Output channel 4 on
  output logic            mode_and_o                  // Latched mode, high = AND
);
  localparam int unsigned NSYNC = 8;

  logic [NSYNC-1:0] pins_async;
  logic [NSYNC-1:0] pins_sync;
  logic             sclk_s;
  logic             cs_n_s;
  logic             si_s;
  logic             strap_s;
  logic [3:0]       par_s;

  assign pins_async = {spi_sclk_i, spi_cs_n_i, spi_si_i, input_polarity_strap_i,
                       parallel_channel_input_4_i, parallel_channel_input_3_i,
                       parallel_channel_input_2_i, parallel_channel_input_1_i};

  // Chip select and strap reset to their idle-high levels, so reset release
  // neither fakes a frame edge nor flips the input polarity for two cycles
  qsoc_sync #(
    .WIDTH   (NSYNC),
    .RST_VAL (qsoc_pkg::SYNC_IDLE)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (pins_async),
    .sync_o  (pins_sync)
  );

  assign sclk_s  = pins_sync[7];
  assign si_s    = pins_sync[5];
  assign strap_s = pins_sync[4];
  assign par_s   = pins_sync[3:0];

  assign cs_n_s = pins_sync[6];

  // Chip select idle value after reset is high; a second flop gives a clean edge history
  logic cs_n_q;
  logic sclk_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= cs_n_s;
      sclk_q <= sclk_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic selected;

  assign selected  = ~cs_n_s & ~cs_n_q;
  assign cs_fall   = cs_n_q & ~cs_n_s;
  assign cs_rise   = ~cs_n_q & cs_n_s;
  assign sclk_fall = selected & sclk_q & ~sclk_s;
  assign sclk_rise = selected & ~sclk_q & sclk_s;

  // Parallel inputs made active high
  logic [3:0] par_active;
  assign par_active = strap_s ? par_s : ~par_s;

  function automatic logic is_special(input logic [3:0] cmd);
    is_special = (cmd == qsoc_pkg::CMD_DIAG) || (cmd == qsoc_pkg::CMD_READBACK) ||
                 (cmd == qsoc_pkg::CMD_ECHO);
  endfunction

  // Receive shift register
  logic [7:0] rx_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_q <= qsoc_pkg::SHIFT_RESET;
    end
    else if (sclk_fall)
    begin
      rx_q <= {rx_q[6:0], si_s};
    end
  end

  // Transmit shift register; echo flag set by previous frame
  logic       echo_q;
  logic       readback_q;
  logic [7:0] tx_q;
  logic       so_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_q <= qsoc_pkg::SHIFT_RESET;
      so_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      if (readback_q)
      begin
        tx_q <= {par_active, ~channel_fault_flag_i};
        so_q <= par_active[3];
      end
      else
      begin
        tx_q <= diag_status_i;
        so_q <= diag_status_i[7];
      end
    end
    else if (sclk_rise)
    begin
      tx_q <= {tx_q[6:0], 1'b1};
      so_q <= tx_q[6];
    end
  end

  // Echo path passes the synchronised serial input si_s; the loop opens at the frame end
  assign spi_so_o    = echo_q ? si_s : so_q;
  assign spi_so_oe_o = ~cs_n_q;

  // Frame end: decode command, latch mode and data
  logic [3:0] cmd;
  logic [3:0] data;
  logic       frame_done;
  logic       mode_q;
  logic [3:0] buf_q;
  logic [2:0] bit_cnt_q;
  logic       full_q;

  assign cmd  = rx_q[qsoc_pkg::CMD_MSB:qsoc_pkg::CMD_LSB];
  assign data = rx_q[3:0];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_q <= 3'h0;
      full_q    <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_cnt_q <= 3'h0;
      full_q    <= 1'b0;
    end
    else if (sclk_fall)
    begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'(qsoc_pkg::FRAME_BITS - 1))
      begin
        full_q <= 1'b1;
      end
    end
  end

  // Short frames carry no valid command and are dropped
  assign frame_done = cs_rise & full_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      echo_q     <= 1'b0;
      readback_q <= 1'b0;
    end
    else if (frame_done)
    begin
      echo_q     <= (cmd == qsoc_pkg::CMD_ECHO);
      readback_q <= (cmd == qsoc_pkg::CMD_READBACK);
    end
    else if (cs_rise)
    begin
      echo_q     <= 1'b0;
      readback_q <= 1'b0;
    end
  end

  // Diagnosis-only is a one-frame no-op, so nothing persists for it
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= qsoc_pkg::MODE_RESET;
    end
    else if (frame_done)
    begin
      if (cmd == qsoc_pkg::CMD_OR)
      begin
        mode_q <= qsoc_pkg::MODE_OR;
      end
      else if (cmd == qsoc_pkg::CMD_AND)
      begin
        mode_q <= qsoc_pkg::MODE_AND;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      buf_q <= qsoc_pkg::OUT_RESET;
    end
    else if (frame_done && !is_special(cmd))
    begin
      buf_q <= data;
    end
  end

  // Per channel latch, combined with the mode in force after this frame
  logic [3:0] out_q;
  logic [3:0] out_d;

  assign out_d = mode_q ? (par_active & buf_q) : (par_active | buf_q);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_q <= qsoc_pkg::OUT_RESET;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign power_channel_output_1_o = out_q[0];
  assign power_channel_output_2_o = out_q[1];
  assign power_channel_output_3_o = out_q[2];
  assign power_channel_output_4_o = out_q[3];
  assign mode_and_o               = mode_q;
endmodule

/* qsoc_top_asserts.sv */
// Purpose: Port checker for the quad switch output control block
// Assumes: Pins far slower than clk_i; a few clocks of sync lag
// Notes:   Quiet counter gives pin and select lag room to settle
`timescale 1ns/1ps
module qsoc_top_asserts (
  input wire logic clk_i,                      // Clock
  input wire logic rst_n_i,                    // Reset
  input wire logic spi_cs_n_i,                 // Select
  input wire logic spi_so_oe_o,                // Out enable
  input wire logic mode_and_o,                 // Mode
  input wire logic input_polarity_strap_i,     // Strap
  input wire logic parallel_channel_input_1_i, // Input 1
  input wire logic parallel_channel_input_3_i, // Input 3
  input wire logic power_channel_output_1_o,   // Output 1
  input wire logic power_channel_output_3_o    // Output 3
);
  logic [4:0] quiet_q;
  wire  logic [2:0] pins = {input_polarity_strap_i, parallel_channel_input_3_i,
                            parallel_channel_input_1_i};
  wire  logic [1:0] outs = {power_channel_output_3_o, power_channel_output_1_o};
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      quiet_q <= 5'h00;
    end
    else
    begin
      quiet_q <= !(spi_cs_n_i && $stable(pins)) ? 5'h00 :
                 (quiet_q == 5'h1f) ? quiet_q : quiet_q + 5'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_desel; spi_cs_n_i [*6]; endsequence
  sequence s_sel; !spi_cs_n_i [*6]; endsequence
  a_reset_all_off: assert property (disable iff (1'b0) !rst_n_i |->
    outs == 2'h0 && !mode_and_o) else $error("outputs on in reset");
  a_so_released: assert property (s_desel |-> !spi_so_oe_o)
    else $error("serial out driven while deselected");
  a_so_driven: assert property (s_sel |-> spi_so_oe_o)
    else $error("serial out idle while selected");
  a_mode_holds: assert property (quiet_q > 5'h0c |-> $stable(mode_and_o))
    else $error("mode changed between frames");
  a_outs_hold: assert property (quiet_q > 5'h0c |-> $stable(outs))
    else $error("outputs changed between frames");
  a_or_combine: assert property ((!mode_and_o && input_polarity_strap_i &&
    parallel_channel_input_1_i) [*8] |-> power_channel_output_1_o)
    else $error("or mode output 1 off");
  a_and_gate: assert property ((mode_and_o && input_polarity_strap_i &&
    !parallel_channel_input_3_i) [*8] |-> !power_channel_output_3_o)
    else $error("and mode output 3 on");
  a_low_polarity: assert property ((!mode_and_o && !input_polarity_strap_i &&
    !parallel_channel_input_1_i) [*8] |-> power_channel_output_1_o)
    else $error("low active input 1 ignored");
endmodule
bind qsoc_top qsoc_top_asserts i_qsoc_top_asserts (.*);

/* qsoc_host.sv */
// Purpose: Serial master model for the switch block
// Assumes: si set two clocks after sclk fall, taken by the block on sclk fall
// Notes:   so read just before each rise, so the first bit is not lost
`timescale 1ns/1ps
module qsoc_host (
  input  wire logic clk_i,  // Bench clock
  input  wire logic so_i,   // Resolved serial out
  output logic      sclk_o, // Serial clock
  output logic      cs_n_o, // Select
  output logic      si_o    // Serial in
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    si_o   = tx[7];
    repeat (10) @(negedge clk_i);
    // Data moves two clocks after the fall, clear of the block's sample point
    for (int i = 7; i >= 0; i--)
    begin
      rx[i]  = so_i;
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      repeat (2) @(negedge clk_i);
      si_o   = tx[(i + 7) % 8];
      repeat (2) @(negedge clk_i);
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    si_o   = ~si_o;
    repeat (12) @(negedge clk_i);
  endtask
endmodule

/* qsoc_top_tb.sv */
// Purpose: Self-checking bench for the quad switch output control block
// Assumes: Host model makes 80 ns serial clock inside frames only
// Notes:   Expected values are worked out by hand from the command set
`timescale 1ns/1ps
module qsoc_top_tb;
  logic       clk_i;
  logic       rst_n_i;
  logic       strap;
  logic [3:0] par;
  logic [7:0] rx;
  wire  logic sclk, cs_n, si, so, so_oe, mode;
  wire  logic [3:0] outs;
  wire  logic so_line = so_oe ? so : 1'bz;
  int         n_fail = 0;
  int         cmp_count = 0;
  qsoc_top i_qsoc_top (
    .clk_i                      (clk_i),
    .rst_n_i                    (rst_n_i),
    .spi_sclk_i                 (sclk),
    .spi_cs_n_i                 (cs_n),
    .spi_si_i                   (si),
    .spi_so_o                   (so),
    .spi_so_oe_o                (so_oe),
    .input_polarity_strap_i     (strap),
    .parallel_channel_input_1_i (par[0]),
    .parallel_channel_input_2_i (par[1]),
    .parallel_channel_input_3_i (par[2]),
    .parallel_channel_input_4_i (par[3]),
    .diag_status_i              (8'hb4),
    .channel_fault_flag_i       (4'h5),
    .power_channel_output_1_o   (outs[0]),
    .power_channel_output_2_o   (outs[1]),
    .power_channel_output_3_o   (outs[2]),
    .power_channel_output_4_o   (outs[3]),
    .mode_and_o                 (mode)
  );
  qsoc_host i_qsoc_host (
    .clk_i  (clk_i),
    .so_i   (so_line),
    .sclk_o (sclk),
    .cs_n_o (cs_n),
    .si_o   (si)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("Counts: %0d mismatches in %0d compares", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_rx(input logic [7:0] exp);
    cmp_count++;
    if (rx !== exp)
    begin
      n_fail++;
      $display("Error t=%0t so byte %h want %h", $time, rx, exp);
    end
  endtask
  // Packed as mode, then outputs 4 down to 1
  task automatic chk_out(input logic [4:0] exp);
    cmp_count++;
    if ({mode, outs} !== exp)
    begin
      n_fail++;
      $display("Error t=%0t outputs %h want %h", $time, {mode, outs}, exp);
    end
  endtask
  task automatic go(input logic [7:0] b);
    i_qsoc_host.xfer(b, rx);
  endtask
  initial
  begin
    #200us;
    n_fail++;
    $display("Error t=%0t watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    rst_n_i = 1'b1;
    strap   = 1'b1;
    par     = 4'h0;
    // A real falling edge, so the asynchronous reset is not lost at time zero
    #1;
    rst_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk_out(5'h00);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    go(8'h39);
    chk_rx(8'hb4);
    chk_out(5'h09);
    go(8'h7d);
    chk_out(5'h0d);
    par = 4'h3;
    go(8'hf2);
    chk_out(5'h12);
    go(8'h9d);
    chk_out(5'h11);
    go(8'h0f);
    chk_out(5'h11);
    go(8'h0f);
    go(8'h5e);
    chk_out(5'h12);
    go(8'hcf);
    chk_out(5'h12);
    go(8'h00);
    chk_rx(8'h3a);
    go(8'ha0);
    chk_out(5'h12);
    go(8'h0c);
    chk_rx(8'h0c);
    go(8'h00);
    chk_rx(8'hb4);
    strap = 1'b0;
    par   = 4'he;
    go(8'h30);
    chk_out(5'h01);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk_out(5'h00);
    rst_n_i = 1'b1;
    repeat (20) @(negedge clk_i);
    chk_out(5'h01);
    report_and_stop();
  end
endmodule
